/* File: logic/srfc_pkg.sv */
/*
 * constants, types and helper functions of the serial register frame checker.
 * assumes a 100 MHz system clock.
 */
`default_nettype none

package srfc_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int GAP_TIME_MS   = 10;
	localparam int GAP_CYCLES    = GAP_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int GAP_W         = 21;

	// ****************************************
	// sizes and frame layout
	// ****************************************
	localparam int MAX_WORDS = 20;
	localparam int BUF_DEPTH = 64;
	localparam int IDX_W     = 6;

	localparam logic [IDX_W-1:0] OFS_ADDR    = 6'h00;
	localparam logic [IDX_W-1:0] OFS_FUNC    = 6'h01;
	localparam logic [IDX_W-1:0] OFS_REG     = 6'h02;
	localparam logic [IDX_W-1:0] OFS_CNT     = 6'h04;
	localparam logic [IDX_W-1:0] OFS_BCNT    = 6'h06;
	localparam logic [IDX_W-1:0] OFS_WR1_DAT = 6'h04;
	localparam logic [IDX_W-1:0] OFS_WRN_DAT = 6'h07;
	localparam logic [IDX_W-1:0] OFS_RD_DAT  = 6'h03;
	localparam logic [IDX_W-1:0] ECHO_LEN    = 6'h06;

	// ****************************************
	// codes and characters
	// ****************************************
	localparam logic [7:0]  FN_READ     = 8'h03;
	localparam logic [7:0]  FN_WR_ONE   = 8'h06;
	localparam logic [7:0]  FN_WR_MULTI = 8'h10;
	localparam logic [7:0]  ADDR_BCAST  = 8'h00;
	localparam logic [7:0]  CH_COLON    = 8'h3a;
	localparam logic [7:0]  CH_CR       = 8'h0d;
	localparam logic [7:0]  CH_LF       = 8'h0a;
	localparam logic [15:0] CRC_PRESET  = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'ha001;

	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_WRITE, ST_READ, ST_TX} srfc_state_t;
	typedef enum logic [2:0] {PH_SOF, PH_DATA, PH_CK0, PH_CK1, PH_CR, PH_LF, PH_DONE} srfc_phase_t;

	// ****************************************
	// hex character helpers
	// ****************************************
	function automatic logic [4:0] srfc_hex_dec(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			return {1'b1, c[3:0]};
		end
		if (c >= 8'h41 && c <= 8'h46) begin
			return {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return 5'h00;
	endfunction

	function automatic logic [7:0] srfc_hex_enc(input logic [3:0] n);
		return (n < 4'ha) ? 8'({4'h0, n} + 8'h30) : 8'({4'h0, n} + 8'h37);
	endfunction

endpackage

`default_nettype wire

/* File: logic/srfc_chk_if.sv */
/*
 * carrier between the frame sequencer and the check engine.
 * assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface srfc_chk_if;
	logic        clear;
	logic        valid;
	logic [7:0]  data;
	logic [15:0] crc;
	logic [7:0]  sum;
	modport eng  (input clear, input valid, input data, output crc, output sum);
	modport user (output clear, output valid, output data, input crc, input sum);
endinterface

`default_nettype wire

/* File: logic/srfc_check.sv */
/*
 * running crc-16 and modulo-256 byte sum over a byte stream.
 * assumes clear and valid come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module srfc_check
	import srfc_pkg::*;
(
	input wire logic   clk_i,
	input wire logic   reset_i,
	srfc_chk_if.eng    chk
);

	// ****************************************
	// byte fold
	// ****************************************
	function automatic logic [15:0] srfc_crc_fold(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			chk.crc <= CRC_PRESET;
		end else if (chk.valid) begin
			chk.crc <= srfc_crc_fold(chk.clear ? CRC_PRESET : chk.crc, chk.data);
		end else if (chk.clear) begin
			chk.crc <= CRC_PRESET;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			chk.sum <= 8'h00;
		end else if (chk.valid) begin
			chk.sum <= 8'((chk.clear ? 8'h00 : chk.sum) + chk.data);
		end else if (chk.clear) begin
			chk.sum <= 8'h00;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	AST_CRC_PRESET: assert property (chk.clear && !chk.valid |=> chk.crc == CRC_PRESET)
		else $error("crc not preset on clear");
	AST_CRC_VECTOR: assert property (chk.clear && chk.valid && chk.data == 8'h01 |=> chk.crc == 16'h807e)
		else $error("crc of single byte wrong");

endmodule

`default_nettype wire

/* File: logic/srfc_frame_checker.sv */
/*
 * frame handler of a serial register-access slave, ascii and rtu framing.
 * assumes a uart on the same clock delivering and taking whole characters,
 * and a register file answering reads in the same cycle as rd_en_o.
 */
`timescale 1ns/10ps
`default_nettype none

module srfc_frame_checker
	import srfc_pkg::*;
#(
	parameter int unsigned GAP_CYC = GAP_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ascii_mode_i,
	input  wire logic [7:0]  slave_addr_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_valid_i,
	output logic      [7:0]  tx_data_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic             wr_en_o,
	output logic      [15:0] wr_addr_o,
	output logic      [15:0] wr_data_o,
	output logic             rd_en_o,
	output logic      [15:0] rd_addr_o,
	input  wire logic [15:0] rd_data_i,
	output logic             frame_ok_o,
	output logic             frame_bad_o
);

	srfc_chk_if chk ();
	srfc_check u_check (.clk_i(clk_i), .reset_i(reset_i), .chk(chk));

	srfc_state_t      state;
	srfc_phase_t      phase;
	logic [7:0]       frame_buf [BUF_DEPTH];
	logic [IDX_W-1:0] len, idx, tx_len, data_ofs, rd_ptr, wcnt, widx;
	logic             in_frame, cr_seen, nib, tnib, rx_err, bcast;
	logic [3:0]       hi_nib;
	logic [GAP_W-1:0] gap_cnt;
	logic [15:0]      base;

	// ****************************************
	// receive decode
	// ****************************************
	logic [4:0]       hx;
	logic             a_start, st_byte, frame_end, tx_slot, tx_feed, last_word;
	logic [7:0]       st_data, lrc;
	logic [15:0]      f_reg, f_cnt;
	logic [IDX_W-1:0] n_pay;
	logic             chk_ok, ok06, ok10, ok03, for_me;

	always_comb begin
		hx        = srfc_hex_dec(rx_data_i);
		a_start   = state == ST_IDLE && ascii_mode_i && rx_valid_i && rx_data_i == CH_COLON;
		st_byte   = state == ST_IDLE && rx_valid_i && (ascii_mode_i ? (in_frame && hx[4] && nib) : 1'b1);
		st_data   = ascii_mode_i ? {hi_nib, hx[3:0]} : rx_data_i;
		frame_end = state == ST_IDLE && (ascii_mode_i ?
			(rx_valid_i && in_frame && cr_seen && rx_data_i == CH_LF) :
			(len != 6'h00 && gap_cnt >= GAP_W'(GAP_CYC)));
		tx_slot   = !tx_valid_o || tx_ready_i;
		tx_feed   = state == ST_TX && tx_slot && phase == PH_DATA && (!ascii_mode_i || !tnib);
		last_word = widx == 6'(wcnt - 6'h01);
		lrc       = 8'(8'h00 - chk.sum);
		f_reg     = {frame_buf[OFS_REG], frame_buf[OFS_REG + 6'h01]};
		f_cnt     = {frame_buf[OFS_CNT], frame_buf[OFS_CNT + 6'h01]};
		n_pay     = 6'(len - (ascii_mode_i ? 6'h01 : 6'h02));
		// a frame that carries its own check value leaves a zero residue
		chk_ok    = !rx_err && len > 6'h03 && (ascii_mode_i ? chk.sum == 8'h00 : chk.crc == 16'h0000);
		for_me    = frame_buf[OFS_ADDR] == slave_addr_i || frame_buf[OFS_ADDR] == ADDR_BCAST;
		ok06      = frame_buf[OFS_FUNC] == FN_WR_ONE && n_pay == ECHO_LEN;
		ok10      = frame_buf[OFS_FUNC] == FN_WR_MULTI && f_cnt != 16'h0000 && f_cnt <= 16'(MAX_WORDS)
			&& {8'h00, frame_buf[OFS_BCNT]} == 16'(f_cnt << 1)
			&& {10'h000, n_pay} == 16'({10'h000, OFS_WRN_DAT} + (f_cnt << 1));
		ok03      = frame_buf[OFS_FUNC] == FN_READ && n_pay == ECHO_LEN
			&& f_cnt != 16'h0000 && f_cnt <= 16'(MAX_WORDS);
	end

	// engine is cleared at frame start and again before the reply
	always_comb begin
		chk.valid = st_byte || tx_feed;
		chk.data  = tx_feed ? frame_buf[idx] : st_data;
		chk.clear = a_start || (st_byte && !ascii_mode_i && len == 6'h00) || state == ST_CHECK;
	end

	// ****************************************
	// sequencing
	// ****************************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: if (frame_end) begin
					state <= ST_CHECK;
				end
				ST_CHECK: if (chk_ok && for_me && (ok06 || ok10)) begin
					state <= ST_WRITE;
				end else if (chk_ok && for_me && ok03 && frame_buf[OFS_ADDR] != ADDR_BCAST) begin
					state <= ST_READ;
				end else begin
					state <= ST_IDLE;
				end
				ST_WRITE: if (last_word) begin
					state <= bcast ? ST_IDLE : ST_TX;
				end
				ST_READ: if (last_word) begin
					state <= ST_TX;
				end
				ST_TX: if (phase == PH_DONE && tx_slot) begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			in_frame <= 1'b0;
			cr_seen  <= 1'b0;
			nib      <= 1'b0;
			hi_nib   <= 4'h0;
			rx_err   <= 1'b0;
			len      <= 6'h00;
			gap_cnt  <= '0;
		end else if (state == ST_CHECK) begin
			len      <= 6'h00;
			in_frame <= 1'b0;
		end else if (state == ST_IDLE) begin
			if (rx_valid_i) begin
				gap_cnt <= '0;
			end else if (gap_cnt < GAP_W'(GAP_CYC)) begin
				gap_cnt <= GAP_W'(gap_cnt + 1'b1);
			end
			if (a_start) begin
				in_frame <= 1'b1;
				cr_seen  <= 1'b0;
				nib      <= 1'b0;
				rx_err   <= 1'b0;
				len      <= 6'h00;
			end else begin
				if (ascii_mode_i && rx_valid_i && in_frame && !frame_end) begin
					if (rx_data_i == CH_CR) begin
						cr_seen <= 1'b1;
					end else if (hx[4] && !cr_seen) begin
						nib    <= !nib;
						hi_nib <= hx[3:0];
					end else begin
						rx_err <= 1'b1;
					end
				end
				if (st_byte) begin
					if (!ascii_mode_i && len == 6'h00) begin
						rx_err <= 1'b0;
					end
					if (len == 6'(BUF_DEPTH - 1)) begin
						rx_err <= 1'b1;
					end else begin
						len <= 6'(len + 6'h01);
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (st_byte && len != 6'(BUF_DEPTH - 1)) begin
			frame_buf[len] <= st_data;
		end
		if (state == ST_CHECK && ok03) begin
			frame_buf[OFS_REG] <= 8'(f_cnt << 1);
		end
		if (rd_en_o) begin
			frame_buf[rd_ptr]         <= rd_data_i[15:8];
			frame_buf[rd_ptr + 6'h01] <= rd_data_i[7:0];
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			widx     <= 6'h00;
			wcnt     <= 6'h01;
			base     <= 16'h0000;
			data_ofs <= OFS_WR1_DAT;
			tx_len   <= ECHO_LEN;
			bcast    <= 1'b0;
			rd_ptr   <= OFS_RD_DAT;
		end else begin
			if (state == ST_CHECK) begin
				widx     <= 6'h00;
				wcnt     <= ok06 ? 6'h01 : f_cnt[IDX_W-1:0];
				base     <= f_reg;
				data_ofs <= ok06 ? OFS_WR1_DAT : OFS_WRN_DAT;
				tx_len   <= ok03 ? 6'(OFS_RD_DAT + {f_cnt[4:0], 1'b0}) : ECHO_LEN;
				bcast    <= frame_buf[OFS_ADDR] == ADDR_BCAST;
				rd_ptr   <= OFS_RD_DAT;
			end else if (state == ST_WRITE || state == ST_READ) begin
				widx <= 6'(widx + 6'h01);
			end
			if (rd_en_o) begin
				rd_ptr <= 6'(rd_ptr + 6'h02);
			end
		end
	end

	// ****************************************
	// register access and status
	// ****************************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_en_o     <= 1'b0;
			wr_addr_o   <= 16'h0000;
			wr_data_o   <= 16'h0000;
			rd_en_o     <= 1'b0;
			rd_addr_o   <= 16'h0000;
			frame_ok_o  <= 1'b0;
			frame_bad_o <= 1'b0;
		end else begin
			wr_en_o     <= state == ST_WRITE;
			wr_addr_o   <= 16'(base + {10'h000, widx});
			wr_data_o   <= {frame_buf[6'(data_ofs + {widx[4:0], 1'b0})],
				frame_buf[6'(data_ofs + {widx[4:0], 1'b0} + 6'h01)]};
			rd_en_o     <= state == ST_READ;
			rd_addr_o   <= 16'(base + {10'h000, widx});
			frame_ok_o  <= state == ST_CHECK && chk_ok;
			frame_bad_o <= state == ST_CHECK && !chk_ok;
		end
	end

	// ****************************************
	// transmit
	// ****************************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			phase      <= PH_DONE;
			idx        <= 6'h00;
			tnib       <= 1'b0;
			tx_data_o  <= 8'h00;
			tx_valid_o <= 1'b0;
		end else if (state == ST_CHECK) begin
			phase      <= ascii_mode_i ? PH_SOF : PH_DATA;
			idx        <= 6'h00;
			tnib       <= 1'b0;
			tx_valid_o <= 1'b0;
		end else if (state != ST_TX) begin
			tx_valid_o <= 1'b0;
		end else if (tx_slot) begin
			tx_valid_o <= phase != PH_DONE;
			unique case (phase)
				PH_SOF: begin
					tx_data_o <= CH_COLON;
					phase     <= PH_DATA;
				end
				PH_DATA: begin
					if (ascii_mode_i) begin
						tx_data_o <= srfc_hex_enc(tnib ? frame_buf[idx][3:0] : frame_buf[idx][7:4]);
						tnib      <= !tnib;
					end else begin
						tx_data_o <= frame_buf[idx];
					end
					if (!ascii_mode_i || tnib) begin
						idx <= 6'(idx + 6'h01);
						if (idx == 6'(tx_len - 6'h01)) begin
							phase <= PH_CK0;
						end
					end
				end
				PH_CK0: begin
					tx_data_o <= ascii_mode_i ? srfc_hex_enc(lrc[7:4]) : chk.crc[7:0];
					phase     <= PH_CK1;
				end
				PH_CK1: begin
					tx_data_o <= ascii_mode_i ? srfc_hex_enc(lrc[3:0]) : chk.crc[15:8];
					phase     <= ascii_mode_i ? PH_CR : PH_DONE;
				end
				PH_CR: begin
					tx_data_o <= CH_CR;
					phase     <= PH_LF;
				end
				PH_LF: begin
					tx_data_o <= CH_LF;
					phase     <= PH_DONE;
				end
				PH_DONE: begin
					tx_data_o <= tx_data_o;
				end
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// raw rtu bytes may equal the cr code, so only ascii replies count
	sequence s_cr_taken;
		ascii_mode_i && tx_valid_o && tx_ready_i && tx_data_o == CH_CR;
	endsequence

	AST_BAD_SILENT: assert property (frame_bad_o |-> !tx_valid_o [*3])
		else $error("reply sent for bad frame");
	AST_BCAST_NO_REPLY: assert property (state == ST_TX |-> !bcast)
		else $error("reply to broadcast");
	AST_WR_LIMIT: assert property (state == ST_WRITE |-> wcnt != 6'h00 && wcnt <= 6'(MAX_WORDS))
		else $error("write count out of range");
	AST_SOF_COLON: assert property (state == ST_TX && phase == PH_SOF && tx_slot |=> tx_data_o == CH_COLON)
		else $error("ascii reply lacks colon");
	AST_CRLF: assert property (s_cr_taken |=> tx_valid_o && tx_data_o == CH_LF)
		else $error("cr not followed by lf");
	AST_RTU_CRC_LO: assert property (state == ST_TX && !ascii_mode_i && phase == PH_CK0 && tx_slot
		|=> tx_valid_o && tx_data_o == chk.crc[7:0])
		else $error("crc low byte not sent first");
	AST_GAP: assert property (state == ST_CHECK && !ascii_mode_i |-> gap_cnt >= GAP_W'(GAP_CYC))
		else $error("rtu frame closed before gap");

endmodule

`default_nettype wire

/* File: tb/srfc_host_model.sv */
/*
 * host model: builds and sends request frames, collects reply characters.
 * assumes one clock shared with the frame checker; the bench calls its tasks.
 */
`timescale 1ns/10ps
`default_nettype none

module srfc_host_model (
	input  wire logic       clk_i,
	input  wire logic       stall_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	output logic      [7:0] rx_data_o,
	output logic            rx_valid_o
);
	logic [7:0] got_q[$];

	// ****************************************
	// link side
	// ****************************************
	initial begin
		tx_ready_o = 1'b1;
		rx_data_o  = 8'h00;
		rx_valid_o = 1'b0;
	end

	// reply capture, ready alternates while stalling
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got_q.push_back(tx_data_i);
		end
		tx_ready_o <= #1 !(stall_i && tx_ready_o);
	end

	task automatic send_byte(input logic [7:0] b);
		@(posedge clk_i);
		#1;
		rx_data_o  = b;
		rx_valid_o = 1'b1;
		@(posedge clk_i);
		#1;
		rx_valid_o = 1'b0;
		rx_data_o  = ~b;
	endtask

	// ****************************************
	// check values and framing
	// ****************************************
	function automatic logic [15:0] crc16(input logic [7:0] m[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (m[i]) begin
			c = c ^ {8'h00, m[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction

	function automatic logic [7:0] lrc(input logic [7:0] m[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (m[i]) s = s + m[i];
		return 8'h00 - s;
	endfunction

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
	endfunction

	function automatic void encode(input logic asc, input logic [7:0] m[$], input bit bad,
			output logic [7:0] w[$]);
		logic [15:0] c;
		logic [7:0]  l;
		c = crc16(m);
		l = lrc(m);
		if (bad) m[m.size() - 1] = m[m.size() - 1] ^ 8'h01;
		w = {};
		if (asc) begin
			w.push_back(8'h3a);
			foreach (m[i]) begin
				w.push_back(hx(m[i][7:4]));
				w.push_back(hx(m[i][3:0]));
			end
			w.push_back(hx(l[7:4]));
			w.push_back(hx(l[3:0]));
			w.push_back(8'h0d);
			w.push_back(8'h0a);
		end else begin
			w = m;
			w.push_back(c[7:0]);
			w.push_back(c[15:8]);
		end
	endfunction
endmodule

`default_nettype wire

/* File: tb/serial_register_frame_checker_tb_top.sv */
/*
 * self-checking bench of the serial register frame checker.
 * assumes the host model is compiled first; silence gap shortened to 50 cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module serial_register_frame_checker_tb_top import srfc_pkg::*; ;
	localparam int GAP = 50;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        ascii_mode_i = 1'b0;
	logic        stall = 1'b0;
	logic [7:0]  tx_data, rx_data;
	logic        tx_valid, tx_ready, rx_valid, wr_en, rd_en, frame_ok, frame_bad;
	logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
	logic [31:0] got_wr[$], exp_wr[$];
	int          errors = 0, n_compared = 0, n_ok = 0, n_bad = 0, cycles = 0;

	// ****************************************
	// clock, design, partner
	// ****************************************
	always #5 clk_i = ~clk_i;
	assign rd_data = rd_addr ^ 16'h5a5a;

	srfc_frame_checker #(.GAP_CYC(GAP)) srfc_frame_checker_inst (
		.clk_i(clk_i), .reset_i(reset_i), .ascii_mode_i(ascii_mode_i),
		.slave_addr_i(8'h01), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_en_o(rd_en),
		.rd_addr_o(rd_addr), .rd_data_i(rd_data), .frame_ok_o(frame_ok),
		.frame_bad_o(frame_bad));

	srfc_host_model srfc_host_model_inst (
		.clk_i(clk_i), .stall_i(stall), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid));

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (wr_en === 1'b1) got_wr.push_back({wr_addr, wr_data});
		if (frame_ok === 1'b1) n_ok++;
		if (frame_bad === 1'b1) n_bad++;
		if (cycles == 40000) begin
			errors++;
			close_out();
		end
	end

	// ****************************************
	// checks and frame helpers
	// ****************************************
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask

	task automatic frame(input string nm, input logic [7:0] m[$], input bit bad,
			input logic [7:0] rep[$], input int e_ok, input int e_bad);
		logic [7:0] w[$];
		int         quiet;
		got_wr = {};
		srfc_host_model_inst.got_q = {};
		n_ok = 0;
		n_bad = 0;
		srfc_host_model_inst.encode(ascii_mode_i, m, bad, w);
		foreach (w[i]) srfc_host_model_inst.send_byte(w[i]);
		quiet = 0;
		for (int k = 0; k < 5000 && quiet < GAP + 30; k++) begin
			@(posedge clk_i);
			quiet = (tx_valid || wr_en || rd_en) ? 0 : quiet + 1;
		end
		#1;
		srfc_host_model_inst.encode(ascii_mode_i, rep, 1'b0, w);
		if (rep.size() == 0) w = {};
		chk(32'(srfc_host_model_inst.got_q.size()), 32'(w.size()), "reply length");
		foreach (w[i]) if (i < srfc_host_model_inst.got_q.size())
			chk(32'(srfc_host_model_inst.got_q[i]), 32'(w[i]), "reply char");
		chk(32'(got_wr.size()), 32'(exp_wr.size()), "write count");
		foreach (exp_wr[i]) if (i < got_wr.size()) chk(got_wr[i], exp_wr[i], "write");
		chk(32'(n_ok), 32'(e_ok), "ok pulses");
		chk(32'(n_bad), 32'(e_bad), "bad pulses");
		exp_wr = {};
		$display("test %s done, ascii %0d", nm, ascii_mode_i);
	endtask

	task automatic wr_one(input logic [7:0] a, input logic [15:0] r, v, input bit bad);
		logic [7:0] m[$];
		logic [7:0] rep[$];
		m = '{a, FN_WR_ONE, r[15:8], r[7:0], v[15:8], v[7:0]};
		if (!bad && a inside {8'h00, 8'h01}) exp_wr.push_back({r, v});
		if (!bad && a == 8'h01) rep = m;
		frame("single write", m, bad, rep, 32'(!bad), 32'(bad));
	endtask

	task automatic wr_n(input logic [15:0] r, input logic [15:0] d[$]);
		logic [7:0] m[$];
		logic [7:0] rep[$];
		m = '{8'h01, FN_WR_MULTI, r[15:8], r[7:0], 8'h00, 8'(d.size()), 8'(2 * d.size())};
		foreach (d[i]) begin
			m.push_back(d[i][15:8]);
			m.push_back(d[i][7:0]);
			if (d.size() <= MAX_WORDS) exp_wr.push_back({16'(r + i), d[i]});
		end
		if (d.size() <= MAX_WORDS) rep = m[0:5];
		frame("multi write", m, 1'b0, rep, 1, 0);
	endtask

	task automatic rd_n(input logic [15:0] r, input int n);
		logic [7:0]  m[$];
		logic [7:0]  rep[$];
		logic [15:0] v;
		m = '{8'h01, FN_READ, r[15:8], r[7:0], 8'h00, 8'(n)};
		rep = '{8'h01, FN_READ, 8'(2 * n)};
		for (int k = 0; k < n; k++) begin
			v = 16'(r + k) ^ 16'h5a5a;
			rep.push_back(v[15:8]);
			rep.push_back(v[7:0]);
		end
		frame("read", m, 1'b0, rep, 1, 0);
	endtask

	function automatic void rnd(input int n, output logic [15:0] d[$]);
		d = {};
		repeat (n) d.push_back(16'($urandom));
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [15:0] d[$];
		void'($urandom(29123));
		repeat (5) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		for (int md = 0; md < 2; md++) begin
			ascii_mode_i = md[0];
			wr_one(8'h01, 16'h0100, 16'h1770, 1'b0);
			wr_n(16'h0500, '{16'h1388, 16'h0fa0});
			rnd(MAX_WORDS, d);
			wr_n(16'($urandom), d);
			rnd(MAX_WORDS + 1, d);
			wr_n(16'($urandom), d);
			wr_one(8'h00, 16'($urandom), 16'($urandom), 1'b0);
			wr_one(8'h02, 16'($urandom), 16'($urandom), 1'b0);
			rd_n(16'h2102, 2);
			wr_one(8'h01, 16'($urandom), 16'($urandom), 1'b1);
			stall = 1'b1;
			wr_one(8'h01, 16'($urandom), 16'($urandom), 1'b0);
			stall = 1'b0;
		end
		repeat (6) begin
			ascii_mode_i = 1'($urandom);
			wr_one(8'h01, 16'($urandom), 16'($urandom), 1'b0);
		end
		close_out();
	end
endmodule

`default_nettype wire
